//--- src/erd_pkg.sv
// erd_pkg: register map, field layout and limits of the receive dma channel.
// assumes: one byte-wide receive stream and one 32-bit memory write port.
package erd_pkg;
   // register offsets (byte addresses on a 32-bit register port)
   localparam logic [7:0]  ERD_OFF_STATUS   = 8'h00;
   localparam logic [7:0]  ERD_OFF_ADDR_EN  = 8'h04;
   localparam logic [7:0]  ERD_OFF_CTRL     = 8'h08;
   // status word fields
   localparam int          ERD_ST_CS        = 17;
   localparam int          ERD_ST_TOO_LONG  = 16;
   localparam int          ERD_ST_RUNT      = 15;
   localparam int          ERD_ST_WDOG      = 14;
   localparam int          ERD_LEN_W        = 14;
   // address/enable fields
   localparam int          ERD_AE_ADDR_LSB  = 5;
   localparam int          ERD_BASE_W       = 27;
   localparam int          ERD_AE_RSVD      = 4;
   localparam int          ERD_AE_BUF_LSB   = 2;
   localparam int          ERD_AE_DONE      = 1;
   localparam int          ERD_AE_EN        = 0;
   // control fields
   localparam int          ERD_CT_JUMBO     = 0;
   localparam int          ERD_CT_VLAN_LSB  = 1;
   localparam int          ERD_CT_APS       = 3;
   localparam int          ERD_CT_IRQ_EN    = 4;
   localparam logic [4:0]  ERD_CTRL_RST     = 5'h00;
   // frame size limits in bytes
   localparam logic [13:0] ERD_MAX_NORMAL   = 14'd1500;
   localparam logic [13:0] ERD_MAX_VLAN1    = 14'd1518;
   localparam logic [13:0] ERD_MAX_VLAN2    = 14'd1538;
   localparam logic [13:0] ERD_STORE_NORMAL = 14'h0800;
   localparam logic [13:0] ERD_STORE_JUMBO  = 14'h2800;
   localparam logic [13:0] ERD_COLL_WINDOW  = 14'd64;
   // watchdog limits: twice the stored maximum, one byte time per clock
   localparam logic [14:0] ERD_WD_NORMAL    = 15'({1'b0, ERD_STORE_NORMAL} * 2);
   localparam logic [14:0] ERD_WD_JUMBO     = 15'({1'b0, ERD_STORE_JUMBO} * 2);
endpackage : erd_pkg

//--- src/erd_word_pack.sv
// erd_word_pack: packs received bytes into words and writes them to memory.
// assumes: memory write port takes a word when o_mem_wr and i_mem_ready.
module erd_word_pack (
   // clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_nrst,
   // frame control
   input  wire logic                          i_clr,
   input  wire logic [erd_pkg::ERD_BASE_W-1:0] i_base,
   input  wire logic                          i_byte_vld,
   input  wire logic [7:0]                    i_byte,
   input  wire logic                          i_flush,
   output logic                               o_ready,
   output logic                               o_empty,
   // memory write port
   output logic [31:0]                        o_mem_addr,
   output logic [31:0]                        o_mem_data,
   output logic [3:0]                         o_mem_be,
   output logic                               o_mem_wr,
   input  wire logic                          i_mem_ready
);
   import erd_pkg::*;

   logic [31:0] word_q;
   logic [3:0]  be_q;
   logic [1:0]  lane_q;
   logic        pend_q;
   logic [29:0] waddr_q;
   logic        take;
   logic        sent;

   // one word in flight at a time: cheap, costs a stall cycle per word
   assign o_ready    = !pend_q;
   assign o_empty    = !pend_q && (be_q == 4'h0);
   assign take       = i_byte_vld && !pend_q;
   assign sent       = pend_q && i_mem_ready;
   assign o_mem_addr = {waddr_q, 2'b00};
   assign o_mem_data = word_q;
   assign o_mem_be   = be_q;
   assign o_mem_wr   = pend_q;

   // byte lanes of the assembly word
   for (genvar g = 0; g < 4; g++) begin : g_lane
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            word_q[8*g +: 8] <= 8'h00;
         end else if (take && lane_q == 2'(g)) begin
            word_q[8*g +: 8] <= i_byte;
         end
      end
   end

   // lane enables, cleared once the word is taken
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         be_q <= 4'h0;
      end else if (i_clr || sent) begin
         be_q <= 4'h0;
      end else if (take) begin
         be_q[lane_q] <= 1'b1;
      end
   end

   // lane pointer and pending flag
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lane_q <= 2'h0;
         pend_q <= 1'b0;
      end else if (i_clr) begin
         lane_q <= 2'h0;
         pend_q <= 1'b0;
      end else begin
         if (take) begin
            lane_q <= lane_q + 2'h1;
         end
         if (sent) begin
            pend_q <= 1'b0;
         end else if (take && lane_q == 2'h3) begin
            pend_q <= 1'b1;
         end else if (i_flush && !pend_q && be_q != 4'h0) begin
            pend_q <= 1'b1; // partial last word
         end
      end
   end

   // word address, base is line aligned
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         waddr_q <= 30'h0;
      end else if (i_clr) begin
         waddr_q <= {i_base, 3'h0};
      end else if (sent) begin
         waddr_q <= waddr_q + 30'h1;
      end
   end
endmodule : erd_word_pack

//--- src/erd_rx_dma.sv
// erd_rx_dma: receive dma channel with buffer address/enable and status word.
// assumes: mac byte stream and memory port on i_ref_clk; software on the
// plain register port.
module erd_rx_dma #(
   parameter logic [14:0] P_WD_NORMAL = erd_pkg::ERD_WD_NORMAL,
   parameter logic [14:0] P_WD_JUMBO  = erd_pkg::ERD_WD_JUMBO
) (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_nrst,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   // mac receive stream
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   input  wire logic        i_rx_sof,
   input  wire logic        i_rx_eof,
   input  wire logic        i_rx_coll,
   input  wire logic        i_rx_abort,
   output logic             o_rx_ready,
   output logic             o_auto_pad_strip,
   // memory write port
   output logic [31:0]      o_mem_addr,
   output logic [31:0]      o_mem_data,
   output logic [3:0]       o_mem_be,
   output logic             o_mem_wr,
   input  wire logic        i_mem_ready,
   // interrupt
   input  wire logic        i_peer_done,
   output logic             o_dma_irq
);
   import erd_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ARMED, ST_RECV, ST_FLUSH, ST_STATUS, ST_FINISH
   } erd_state_t;

   erd_state_t             st_q;
   logic [ERD_BASE_W-1:0]  addr_q;
   logic                   en_q;
   logic                   done_q;
   logic [1:0]             cur_buf_q;
   logic [4:0]             ctrl_q;
   logic [ERD_LEN_W-1:0]   cnt_q;
   logic [ERD_LEN_W-1:0]   nxt_cnt;
   logic [14:0]            wd_q;
   logic                   coll_late_q;
   logic                   coll_early_q;
   logic                   wdog_q;
   logic [17:0]            stat_q;
   logic                   pk_ready;
   logic                   pk_empty;
   logic                   start;
   logic                   sof_now;
   logic                   take;
   logic                   acc;
   logic                   hit_lim;
   logic                   wd_exp;
   logic                   end_frame;
   logic                   done_clr;
   logic                   wr_ae;
   logic [ERD_LEN_W-1:0]   lim;

   // largest legal frame for the tagging mode
   function automatic logic [ERD_LEN_W-1:0] max_len(input logic [1:0] vlan);
      unique case (vlan)
         2'h1:    max_len = ERD_MAX_VLAN1;
         2'h2:    max_len = ERD_MAX_VLAN2;
         2'h3:    max_len = ERD_MAX_VLAN2;
         default: max_len = ERD_MAX_NORMAL;
      endcase
   endfunction : max_len

   // register port decode
   assign wr_ae   = i_wr && i_addr == ERD_OFF_ADDR_EN;
   assign start   = wr_ae && st_q == ST_IDLE && i_wdata[ERD_AE_EN];
   assign done_clr = wr_ae && !i_wdata[ERD_AE_DONE];

   // stream acceptance; frames outside an armed buffer are drained and lost
   assign sof_now    = st_q == ST_ARMED && i_rx_sof;
   assign take       = sof_now || st_q == ST_RECV;
   assign o_rx_ready = take ? pk_ready : 1'b1;
   assign acc        = take && i_rx_valid && pk_ready;
   assign nxt_cnt    = sof_now ? 14'h0001 : cnt_q + 14'h0001;
   assign lim        = ctrl_q[ERD_CT_JUMBO] ? ERD_STORE_JUMBO : ERD_STORE_NORMAL;
   assign hit_lim    = acc && !i_rx_eof && nxt_cnt == lim;
   assign wd_exp     = st_q == ST_RECV &&
                       wd_q >= (ctrl_q[ERD_CT_JUMBO] ? P_WD_JUMBO : P_WD_NORMAL);
   assign end_frame  = (acc && i_rx_eof) || hit_lim || wd_exp ||
                       (st_q == ST_RECV && i_rx_abort);

   assign o_auto_pad_strip = ctrl_q[ERD_CT_APS];
   // level interrupt, no edge to lose when several buffers finish together
   assign o_dma_irq = ctrl_q[ERD_CT_IRQ_EN] && (done_q || i_peer_done);

   // transaction sequencer
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (start) begin
                  st_q <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (acc) begin
                  st_q <= end_frame ? ST_FLUSH : ST_RECV;
               end
            end
            ST_RECV: begin
               if (end_frame) begin
                  st_q <= ST_FLUSH;
               end
            end
            ST_FLUSH: begin
               if (pk_empty) begin
                  st_q <= ST_STATUS;
               end
            end
            ST_STATUS: st_q <= ST_FINISH; // status lands one edge before done
            ST_FINISH: st_q <= ST_IDLE;
         endcase
      end
   end

   // byte counter, frame length in bytes
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 14'h0000;
      end else if (acc) begin
         cnt_q <= nxt_cnt;
      end
   end

   // receive watchdog, counts clocks from the first byte
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wd_q <= 15'h0000;
      end else if (sof_now) begin
         wd_q <= 15'h0000;
      end else if (st_q == ST_RECV) begin
         wd_q <= wd_q + 15'h0001;
      end
   end

   // collision and timeout flags gathered during the frame
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         coll_late_q  <= 1'b0;
         coll_early_q <= 1'b0;
         wdog_q       <= 1'b0;
      end else if (sof_now) begin
         coll_late_q  <= 1'b0;
         coll_early_q <= 1'b0;
         wdog_q       <= hit_lim;
      end else if (st_q == ST_RECV) begin
         if (i_rx_coll && cnt_q >= ERD_COLL_WINDOW) begin
            coll_late_q <= 1'b1;
         end
         if ((i_rx_coll || i_rx_abort) && cnt_q < ERD_COLL_WINDOW) begin
            coll_early_q <= 1'b1;
         end
         if (hit_lim || wd_exp) begin
            wdog_q <= 1'b1;
         end
      end
   end

   // status word, written once the last data word has left
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stat_q <= 18'h00000;
      end else if (st_q == ST_STATUS) begin
         stat_q[ERD_ST_CS] <= coll_late_q;
         stat_q[ERD_ST_TOO_LONG] <= cnt_q > max_len(ctrl_q[ERD_CT_VLAN_LSB +: 2]);
         stat_q[ERD_ST_RUNT] <= coll_early_q || cnt_q < ERD_COLL_WINDOW;
         stat_q[ERD_ST_WDOG] <= wdog_q;
         stat_q[ERD_LEN_W-1:0] <= cnt_q;
      end
   end

   // buffer address; dropped once enabled, so software must write it again
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         addr_q <= '0;
      end else if (start) begin
         addr_q <= '0;
      end else if (wr_ae && st_q == ST_IDLE) begin
         addr_q <= i_wdata[31:ERD_AE_ADDR_LSB];
      end
   end

   // enable and done handshake; a set in the clearing cycle wins
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         en_q   <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (start) begin
            en_q <= 1'b1;
         end else if (st_q == ST_FINISH) begin
            en_q <= 1'b0;
         end
         if (st_q == ST_FINISH) begin
            done_q <= 1'b1;
         end else if (done_clr) begin
            done_q <= 1'b0;
         end
      end
   end

   // current buffer index steps after each completed buffer
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cur_buf_q <= 2'h0;
      end else if (st_q == ST_FINISH) begin
         cur_buf_q <= cur_buf_q + 2'h1;
      end
   end

   // control register
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q <= ERD_CTRL_RST;
      end else if (i_wr && i_addr == ERD_OFF_CTRL) begin
         ctrl_q <= i_wdata[4:0];
      end
   end

   // read data, valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 32'h00000000;
      end else if (i_rd) begin
         unique case (i_addr)
            ERD_OFF_STATUS:  o_rdata <= {14'h0000, stat_q};
            ERD_OFF_ADDR_EN: o_rdata <= {addr_q, 1'b0, cur_buf_q, done_q, en_q};
            ERD_OFF_CTRL:    o_rdata <= {27'h0000000, ctrl_q};
            default:         o_rdata <= 32'h00000000;
         endcase
      end else begin
         o_rdata <= 32'h00000000;
      end
   end

   // byte packing and memory writes
   erd_word_pack u_pack (
      .i_ref_clk  (i_ref_clk),
      .i_nrst     (i_nrst),
      .i_clr      (start),
      .i_base     (i_wdata[31:ERD_AE_ADDR_LSB]),
      .i_byte_vld (take && i_rx_valid),
      .i_byte     (i_rx_data),
      .i_flush    (st_q == ST_FLUSH),
      .o_ready    (pk_ready),
      .o_empty    (pk_empty),
      .o_mem_addr (o_mem_addr),
      .o_mem_data (o_mem_data),
      .o_mem_be   (o_mem_be),
      .o_mem_wr   (o_mem_wr),
      .i_mem_ready(i_mem_ready)
   );

   // checks; one clock domain, quiet while reset is low
   default clocking chk_clk @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   // closing steps of a buffer: status first, done one edge later
   sequence s_close;
      st_q == ST_STATUS ##1 st_q == ST_FINISH ##1 done_q;
   endsequence

   sequence s_clear_quiet;
      done_clr && !i_peer_done && st_q == ST_IDLE ##1 !i_peer_done;
   endsequence

   a_done_after_stat: assert property (st_q == ST_FLUSH && pk_empty |=> s_close)
      else $error("done not raised two cycles after status");
   a_done_stable_st: assert property ($rose(done_q) |-> $stable(stat_q))
      else $error("status changed as done rose");
   a_done_clear: assert property (done_clr && st_q != ST_FINISH |=> !done_q)
      else $error("done not cleared by software write");
   a_irq_withdraw: assert property (s_clear_quiet |-> !o_dma_irq)
      else $error("interrupt still high after done cleared");
   a_irq_level: assert property (ctrl_q[ERD_CT_IRQ_EN] && done_q |-> o_dma_irq)
      else $error("interrupt low while done is set");
   a_late_coll: assert property (
      st_q == ST_RECV && i_rx_coll && cnt_q >= ERD_COLL_WINDOW |=> coll_late_q)
      else $error("late collision not flagged");
   a_early_runt: assert property (
      st_q == ST_RECV && (i_rx_coll || i_rx_abort) && cnt_q < ERD_COLL_WINDOW
      |=> coll_early_q)
      else $error("early collision or abort not flagged");
   a_too_long: assert property (
      st_q == ST_STATUS && (cnt_q > ERD_MAX_VLAN2 || cnt_q <= ERD_MAX_NORMAL)
      |=> stat_q[ERD_ST_TOO_LONG] == ($past(cnt_q) > ERD_MAX_VLAN2))
      else $error("too long flag wrong");
   a_no_truncate: assert property (
      acc && st_q == ST_RECV && !i_rx_eof && !i_rx_abort && nxt_cnt < lim && !wd_exp
      |=> st_q == ST_RECV)
      else $error("frame cut before limit");
   a_store_limit: assert property (hit_lim |=> wdog_q && st_q == ST_FLUSH)
      else $error("store limit did not end frame with watchdog flag");
   a_wd_expire: assert property (wd_exp |=> wdog_q ##1 st_q != ST_RECV)
      else $error("watchdog expiry not flagged");
   a_start_arm: assert property (start |=> en_q && st_q == ST_ARMED && addr_q == '0)
      else $error("enable write did not arm the buffer");
   a_cur_buf_step: assert property (
      st_q == ST_FINISH |=> cur_buf_q == $past(cur_buf_q) + 2'h1)
      else $error("current buffer did not step");
   a_len_field: assert property (st_q == ST_STATUS |=> stat_q[13:0] == $past(cnt_q))
      else $error("length field not loaded");
   a_rsvd_zero: assert property (i_rd && i_addr == ERD_OFF_ADDR_EN |=> !o_rdata[4])
      else $error("reserved bit read nonzero");
   a_word_align: assert property (o_mem_wr |-> o_mem_addr[1:0] == 2'h0)
      else $error("memory write not word aligned");
endmodule : erd_rx_dma

//--- sim/erd_mac_mem_model.sv
// erd_mac_mem_model: mac byte source and memory slave facing the receive dma.
// assumes: one clock; the bench pulses i_go with the frame shape held steady.
module erd_mac_mem_model (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_nrst,
   // frame shape from the bench
   input  wire logic        i_go,
   input  wire logic [15:0] i_len,
   input  wire logic [15:0] i_coll_at,
   input  wire logic [15:0] i_abort_at,
   input  wire logic [15:0] i_wait,
   // mac receive stream
   output logic             o_rx_valid,
   output logic [7:0]       o_rx_data,
   output logic             o_rx_sof,
   output logic             o_rx_eof,
   output logic             o_rx_coll,
   output logic             o_rx_abort,
   input  wire logic        i_rx_ready,
   // memory write port
   input  wire logic [31:0] i_mem_addr,
   input  wire logic [31:0] i_mem_data,
   input  wire logic [3:0]  i_mem_be,
   input  wire logic        i_mem_wr,
   output logic             o_mem_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q;
   logic [15:0] wait_q;
   logic        busy_q;
   logic [31:0] mem_q [0:63];
   // byte n carries n, so lanes and addresses are easy to predict
   assign o_rx_valid  = busy_q;
   assign o_rx_data   = busy_q ? cnt_q[7:0] : ~cnt_q[7:0]; // idle line never shows a stale byte
   assign o_rx_sof    = busy_q && cnt_q == 16'h0000;
   assign o_rx_eof    = busy_q && cnt_q == i_len - 16'h0001;
   assign o_rx_coll   = busy_q && i_coll_at != 16'h0000 && cnt_q == i_coll_at;
   assign o_rx_abort  = busy_q && i_abort_at != 16'h0000 && cnt_q == i_abort_at;
   // a frame ends on its last byte or on an abort
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_q <= 1'b0;
         cnt_q  <= 16'h0000;
      end else if (i_go) begin
         busy_q <= 1'b1;
         cnt_q  <= 16'h0000;
      end else if (busy_q && i_rx_ready) begin
         cnt_q <= cnt_q + 16'h0001;
         if (o_rx_eof || o_rx_abort) begin
            busy_q <= 1'b0;
         end
      end
   end
   // slow memory refuses i_wait cycles per word, so the packer must hold its write
   assign o_mem_ready = wait_q >= i_wait;
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_q <= 16'h0000;
         for (int w = 0; w < 64; w++) begin
            mem_q[w] <= 32'h0000_0000;
         end
      end else if (i_mem_wr && o_mem_ready) begin
         wait_q <= 16'h0000;
         for (int b = 0; b < 4; b++) begin
            if (i_mem_be[b]) begin
               mem_q[i_mem_addr[7:2]][8*b +: 8] <= i_mem_data[8*b +: 8];
            end
         end
      end else if (i_mem_wr) begin
         wait_q <= wait_q + 16'h0001;
      end
   end
endmodule : erd_mac_mem_model

//--- sim/tb_ethernet_rx_dma_buffer_status.sv
// tb_ethernet_rx_dma_buffer_status: register-level tests of the receive dma channel.
// assumes: design assertions live in the design; watchdog limits shortened.
module tb_ethernet_rx_dma_buffer_status;
   timeunit 1ns;
   timeprecision 1ps;
   import erd_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        peer_done = 1'b0;
   logic        go = 1'b0;
   logic [15:0] len = 16'h0000;
   logic [15:0] coll_at = 16'h0000;
   logic [15:0] abort_at = 16'h0000;
   logic [15:0] mem_wait = 16'h0000;
   logic [31:0] rdata, mem_addr, mem_data, v;
   logic [7:0]  rx_data;
   logic [3:0]  mem_be;
   logic        rx_valid, rx_sof, rx_eof, rx_coll, rx_abort, rx_ready;
   logic        pad_strip, mem_wr, mem_ready, dma_irq;
   int          miscompares = 0;
   int          check_count = 0;
   int          frames_done = 0;
   int          lim [4] = '{1500, 1518, 1538, 1538};
   int          a;
   always #5 ref_clk = ~ref_clk;
   // watchdog limits cut so the timer path is reachable in a short run
   erd_rx_dma #(.P_WD_NORMAL(15'h0FA0), .P_WD_JUMBO(15'h4E20)) u_erd_rx_dma (
      .i_ref_clk(ref_clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .i_rx_sof(rx_sof), .i_rx_eof(rx_eof), .i_rx_coll(rx_coll),
      .i_rx_abort(rx_abort), .o_rx_ready(rx_ready), .o_auto_pad_strip(pad_strip),
      .o_mem_addr(mem_addr), .o_mem_data(mem_data), .o_mem_be(mem_be),
      .o_mem_wr(mem_wr), .i_mem_ready(mem_ready), .i_peer_done(peer_done),
      .o_dma_irq(dma_irq));
   erd_mac_mem_model u_erd_mac_mem_model (
      .i_ref_clk(ref_clk), .i_nrst(nrst), .i_go(go), .i_len(len), .i_coll_at(coll_at),
      .i_abort_at(abort_at), .i_wait(mem_wait), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data), .o_rx_sof(rx_sof), .o_rx_eof(rx_eof), .o_rx_coll(rx_coll),
      .o_rx_abort(rx_abort), .i_rx_ready(rx_ready), .i_mem_addr(mem_addr),
      .i_mem_data(mem_data), .i_mem_be(mem_be), .i_mem_wr(mem_wr),
      .o_mem_ready(mem_ready));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   // one-cycle strobes, changed just after the edge
   task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= ad;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : reg_wr
   // read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= ad;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd
   function automatic logic [31:0] st_word(logic cs, logic lng, logic rnt, logic wdg, int n);
      return {14'h0000, cs, lng, rnt, wdg, 14'(n)};
   endfunction : st_word
   // arm, send one frame, wait for the done level, check status, clear done
   task automatic frame(input int n, input int c, input int ab, input int w,
                        input logic [31:0] exp, input logic [31:0] mask);
      logic [31:0] s;
      int t;
      t = 0;
      while (rx_valid === 1'b1 && t < 20000) begin
         @(posedge ref_clk);
         #1;
         t++;
      end
      reg_wr(ERD_OFF_ADDR_EN, 32'h0000_0101);
      reg_rd(ERD_OFF_ADDR_EN, s);
      chk("armed addr_en", s, {28'h0000000, 2'(frames_done), 2'b01});
      @(posedge ref_clk);
      len      <= 16'(n);
      coll_at  <= 16'(c);
      abort_at <= 16'(ab);
      mem_wait <= 16'(w);
      go       <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      t = 0;
      while (dma_irq !== 1'b1 && t < 20000) begin
         @(posedge ref_clk);
         #1;
         t++;
      end
      chk("irq on done", {31'h0, dma_irq}, 32'h1);
      reg_rd(ERD_OFF_ADDR_EN, s);
      chk("done bit", s & 32'h2, 32'h2);
      reg_rd(ERD_OFF_STATUS, s);
      chk("status", s & mask, exp);
      mem_wait <= 16'h0000;
      reg_wr(ERD_OFF_ADDR_EN, 32'h0000_0000);
      frames_done++;
      reg_rd(ERD_OFF_ADDR_EN, s);
      chk("done cleared", s & 32'hF, {28'h0000000, 2'(frames_done), 2'b00});
      chk("irq withdrawn", {31'h0, dma_irq}, 32'h0);
   endtask : frame
   // hang guard, about three times the longest expected run
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      $display("ERROR watchdog expired before the tests ended");
      end_sim();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      reg_rd(ERD_OFF_ADDR_EN, v);
      chk("addr_en reset", v, 32'h0);
      reg_rd(ERD_OFF_CTRL, v);
      chk("ctrl reset", v, 32'h0);
      reg_rd(8'h0C, v);
      chk("unmapped read", v, 32'h0);
      reg_wr(ERD_OFF_CTRL, 32'h0000_0008);
      #1;
      chk("pad strip out", {31'h0, pad_strip}, 32'h1);
      reg_wr(ERD_OFF_CTRL, 32'h0000_0010);
      @(posedge ref_clk);
      peer_done <= 1'b1;
      #1;
      chk("peer irq", {31'h0, dma_irq}, 32'h1);
      @(posedge ref_clk);
      peer_done <= 1'b0;
      frame(10, 0, 0, 0, st_word(0, 0, 1, 0, 10), 32'h3FFFF);
      chk("word 0", u_erd_mac_mem_model.mem_q[0], 32'h0302_0100);
      chk("word 1", u_erd_mac_mem_model.mem_q[1], 32'h0706_0504);
      chk("word 2", u_erd_mac_mem_model.mem_q[2], 32'h0000_0908);
      frame(80, 30, 0, 0, st_word(0, 0, 1, 0, 80), 32'h3FFFF);
      frame(80, 70, 0, 0, st_word(1, 0, 0, 0, 80), 32'h3FFFF);
      frame(20, 0, 10, 0, st_word(0, 0, 1, 0, 0), 32'h8000);
      frame(100, 0, 0, 200, st_word(0, 0, 0, 1, 0), 32'h3C000);
      frame(1500, 0, 0, 0, st_word(0, 0, 0, 0, 1500), 32'h3FFFF);
      for (int m = 0; m < 4; m++) begin
         reg_wr(ERD_OFF_CTRL, 32'h10 | 32'(m << 1));
         frame(lim[m] + 1, 0, 0, 0, st_word(0, 1, 0, 0, lim[m] + 1), 32'h3FFFF);
         a = 256 + lim[m];
         chk("last byte", 32'(u_erd_mac_mem_model.mem_q[(a >> 2) % 64][8*(a % 4) +: 8]),
             32'(lim[m] % 256));
      end
      reg_wr(ERD_OFF_CTRL, 32'h0000_0010);
      frame(2049, 0, 0, 0, st_word(0, 1, 0, 1, 2048), 32'h3FFFF);
      reg_wr(ERD_OFF_CTRL, 32'h0000_0011);
      frame(2049, 0, 0, 0, st_word(0, 1, 0, 0, 2049), 32'h3FFFF);
      reg_wr(ERD_OFF_CTRL, 32'h0000_0000);
      @(posedge ref_clk);
      peer_done <= 1'b1;
      #1;
      chk("irq masked", {31'h0, dma_irq}, 32'h0);
      end_sim();
   end
endmodule : tb_ethernet_rx_dma_buffer_status
